// ---- design/pac_control.sv ----
// Purpose: low six bits of the protection control register
// Assumes: wr_en/rd_en are single-cycle strobes from the serial bus slave
// Notes:   bits 7:6 are outside this block and read as zero here
`timescale 1ns/100ps
module pac_control (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// register port
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	input  wire logic [7:0]        wr_data,
	output logic      [7:0]        rd_data,
	// configuration and status from the engine
	input  wire logic [1:0]        enc_policy,
	input  wire logic              receiver_key_ready,
	input  wire logic              authenticated,
	// requests to the engine
	output logic                   auth_enabled,
	output logic                   auth_start_pulse,
	output logic                   auth_restart_pulse,
	output logic                   auth_stop_pulse,
	output logic                   receiver_key_approved,
	output logic                   repeater_list_approved,
	output logic                   encryption_off,
	output logic                   encryption_on,
	// video path
	output pac_pkg::pac_vid_e      video_mode
);
	import pac_pkg::*;

	logic enc_on_reg;
	logic key_ready_q;

	// write decode
	wire wr_auth_on   = wr_en && wr_data[PAC_BIT_AUTH_ON];
	wire wr_auth_off  = wr_en && wr_data[PAC_BIT_AUTH_OFF];
	wire wr_enc_off   = wr_en && wr_data[PAC_BIT_ENC_OFF];
	wire wr_rx_ok     = wr_en && wr_data[PAC_BIT_RX_APPROVED];
	wire wr_list_ok   = wr_en && wr_data[PAC_BIT_LIST_APPROVE];
	wire policy_force = (enc_policy == PAC_POL_ALWAYS);
	wire key_ready_rise = receiver_key_ready && !key_ready_q;

	// auth off wins over auth on when both are written together
	wire next_auth_enabled = wr_auth_off ? 1'b0 :
		(wr_auth_on ? 1'b1 : auth_enabled);
	// a write of one sets, a rising edge of key ready clears; a zero write leaves it alone
	wire next_rx_ok = wr_rx_ok ? 1'b1 :
		(key_ready_rise ? 1'b0 : receiver_key_approved);
	wire next_enc_reg = wr_en ? wr_data[PAC_BIT_ENC_ON] : enc_on_reg;
	wire next_enc_on = policy_force | enc_on_reg;

	wire [7:0] next_rd_data = {2'b00,
		1'b0,
		receiver_key_approved,
		1'b0,
		encryption_on,
		1'b0,
		auth_enabled};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			key_ready_q <= 1'b0;
		end else begin
			key_ready_q <= receiver_key_ready;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			auth_enabled          <= PAC_CTRL_RESET[PAC_BIT_AUTH_ON];
			receiver_key_approved <= PAC_CTRL_RESET[PAC_BIT_RX_APPROVED];
			enc_on_reg            <= PAC_CTRL_RESET[PAC_BIT_ENC_ON];
			encryption_on         <= PAC_CTRL_RESET[PAC_BIT_ENC_ON];
		end else begin
			auth_enabled          <= next_auth_enabled;
			receiver_key_approved <= next_rx_ok;
			enc_on_reg            <= next_enc_reg;
			encryption_on         <= next_enc_on;
		end
	end

	// self-clearing bits become single-cycle pulses
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			auth_start_pulse       <= 1'b0;
			auth_restart_pulse     <= 1'b0;
			auth_stop_pulse        <= 1'b0;
			repeater_list_approved <= 1'b0;
			encryption_off         <= 1'b0;
		end else begin
			auth_start_pulse       <= wr_auth_on && !wr_auth_off && !auth_enabled;
			auth_restart_pulse     <= wr_auth_on && !wr_auth_off && auth_enabled;
			auth_stop_pulse        <= wr_auth_off;
			repeater_list_approved <= wr_list_ok;
			encryption_off         <= wr_enc_off;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			rd_data <= next_rd_data;
		end
	end

	// encryption off only masks the stream; auth state is left alone
	pac_video_select u_video (
		.clk           (clk),
		.arst_n        (arst_n),
		.enc_on        (next_enc_on && !wr_enc_off && !encryption_off),
		.authenticated (authenticated),
		.video_mode    (video_mode)
	);

	a_list_pulse: assert property (
		@(posedge clk) disable iff (!arst_n)
		(repeater_list_approved && !wr_list_ok)
		|=> !repeater_list_approved)
		else $error("list approved pulse held without a write");

	a_list_cause: assert property (
		@(posedge clk) disable iff (!arst_n)
		wr_list_ok
		|=> repeater_list_approved)
		else $error("list approved write gave no pulse");

	a_rx_set: assert property (
		@(posedge clk) disable iff (!arst_n)
		wr_rx_ok
		|=> receiver_key_approved)
		else $error("key approved write did not set the bit");

	a_rx_zero_write: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_en && !wr_data[PAC_BIT_RX_APPROVED] && !key_ready_rise)
		|=> $stable(receiver_key_approved))
		else $error("zero write changed key approved");

	a_rx_hold: assert property (
		@(posedge clk) disable iff (!arst_n)
		(!wr_rx_ok && !key_ready_rise)
		|=> $stable(receiver_key_approved))
		else $error("key approved moved without a cause");

	a_rx_clear: assert property (
		@(posedge clk) disable iff (!arst_n)
		(key_ready_rise && !wr_rx_ok)
		|=> !receiver_key_approved)
		else $error("key approved not cleared on key ready");

	a_rx_only_write: assert property (
		@(posedge clk) disable iff (!arst_n)
		$rose(receiver_key_approved)
		|-> $past(wr_rx_ok))
		else $error("key approved rose without a write");

	a_read_key: assert property (
		@(posedge clk) disable iff (!arst_n)
		rd_en
		|=> (rd_data[PAC_BIT_RX_APPROVED] == $past(receiver_key_approved)))
		else $error("key approved read back wrong");

	a_enc_off_pulse: assert property (
		@(posedge clk) disable iff (!arst_n)
		wr_enc_off
		|=> encryption_off ##1 (!encryption_off || $past(wr_enc_off)))
		else $error("encryption off not a pulse");

	a_enc_off_self: assert property (
		@(posedge clk) disable iff (!arst_n)
		(encryption_off && !wr_enc_off)
		|=> !encryption_off)
		else $error("encryption off pulse did not clear");

	a_enc_off_plain: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_enc_off || encryption_off)
		|=> (video_mode == PAC_VID_PLAIN))
		else $error("video not plain after encryption off");

	a_enc_off_auth: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_enc_off && !wr_auth_on && !wr_auth_off)
		|=> $stable(auth_enabled))
		else $error("encryption off changed auth state");

	a_enc_off_quiet: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_enc_off && !wr_auth_on && !wr_auth_off)
		|=> (!auth_stop_pulse && !auth_start_pulse && !auth_restart_pulse))
		else $error("encryption off sent an auth request");

	a_enc_on_set: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_en && wr_data[PAC_BIT_ENC_ON])
		|=> ##1 encryption_on)
		else $error("encryption on write not taken");

	a_enc_clear_plain: assert property (
		@(posedge clk) disable iff (!arst_n)
		(!policy_force && !enc_on_reg)
		|=> (video_mode == PAC_VID_PLAIN))
		else $error("video not plain with encryption bit clear");

	a_enc_forced: assert property (
		@(posedge clk) disable iff (!arst_n)
		policy_force
		|=> encryption_on)
		else $error("encryption on not forced in always mode");

	a_forced_video: assert property (
		@(posedge clk) disable iff (!arst_n)
		(policy_force && authenticated && !wr_enc_off && !encryption_off)
		|=> (video_mode == PAC_VID_ENCRYPT))
		else $error("video not encrypted in always mode");

	a_forced_read: assert property (
		@(posedge clk) disable iff (!arst_n)
		policy_force ##1 (policy_force && rd_en)
		|=> rd_data[PAC_BIT_ENC_ON])
		else $error("encryption on read zero in always mode");

	a_auth_off: assert property (
		@(posedge clk) disable iff (!arst_n)
		wr_auth_off
		|=> (!auth_enabled && auth_stop_pulse))
		else $error("auth off write did not disable");

	a_stop_self: assert property (
		@(posedge clk) disable iff (!arst_n)
		(auth_stop_pulse && !wr_auth_off)
		|=> !auth_stop_pulse)
		else $error("auth stop pulse did not clear");

	a_off_wins: assert property (
		@(posedge clk) disable iff (!arst_n)
		auth_stop_pulse
		|-> (!auth_start_pulse && !auth_restart_pulse && !auth_enabled))
		else $error("auth off did not win over auth on");

	a_auth_on_set: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_auth_on && !wr_auth_off)
		|=> auth_enabled)
		else $error("auth on write did not enable");

	a_auth_start: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_auth_on && !wr_auth_off && !auth_enabled)
		|=> (auth_start_pulse && !auth_restart_pulse))
		else $error("start not issued while disabled");

	a_auth_restart: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_auth_on && !wr_auth_off && auth_enabled)
		|=> (auth_restart_pulse && !auth_start_pulse))
		else $error("restart not issued while enabled");

	a_pulse_excl: assert property (
		@(posedge clk) disable iff (!arst_n)
		!(auth_start_pulse && auth_restart_pulse))
		else $error("start and restart issued together");

	a_start_single: assert property (
		@(posedge clk) disable iff (!arst_n)
		auth_start_pulse
		|=> !auth_start_pulse)
		else $error("auth start pulse held");

	a_auth_zero: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_en && !wr_data[PAC_BIT_AUTH_ON] && !wr_data[PAC_BIT_AUTH_OFF])
		|=> ($stable(auth_enabled) && !auth_start_pulse && !auth_restart_pulse))
		else $error("zero write changed auth state");

	a_auth_read: assert property (
		@(posedge clk) disable iff (!arst_n)
		rd_en
		|=> (rd_data[PAC_BIT_AUTH_ON] == $past(auth_enabled)))
		else $error("auth on read not current status");

	a_selfclr_read: assert property (
		@(posedge clk) disable iff (!arst_n)
		rd_en
		|=> ((rd_data[PAC_BIT_LIST_APPROVE] == 1'h0) && (rd_data[PAC_BIT_ENC_OFF] == 1'h0)
		&& (rd_data[PAC_BIT_AUTH_OFF] == 1'h0)))
		else $error("self-clearing bit read as one");
endmodule

// ---- design/pac_pkg.sv ----
// Purpose: constants for the protection control bits block
// Assumes: 8-bit register bus, one register reached by a write/read strobe
// Notes:   field positions, reset values and policy codes
package pac_pkg;
	localparam int unsigned PAC_BIT_AUTH_ON      = 0;
	localparam int unsigned PAC_BIT_AUTH_OFF     = 1;
	localparam int unsigned PAC_BIT_ENC_ON       = 2;
	localparam int unsigned PAC_BIT_ENC_OFF      = 3;
	localparam int unsigned PAC_BIT_RX_APPROVED  = 4;
	localparam int unsigned PAC_BIT_LIST_APPROVE = 5;
	localparam logic [7:0]  PAC_CTRL_RESET       = 8'h00;
	localparam logic [1:0]  PAC_POL_AUTHED       = 2'h0;
	localparam logic [1:0]  PAC_POL_REG          = 2'h1;
	localparam logic [1:0]  PAC_POL_ALWAYS       = 2'h2;
	localparam logic [1:0]  PAC_POL_INBAND       = 2'h3;
	typedef enum logic [1:0] {
		PAC_VID_PLAIN,
		PAC_VID_ENCRYPT,
		PAC_VID_BLUE
	} pac_vid_e;
endpackage

// ---- design/pac_video_select.sv ----
// Purpose: choose how outgoing video is sent from the control state
// Assumes: inputs come from logic on clk; enc_on may be combinational
// Notes:   registered output so the top drives it straight from a flop
`timescale 1ns/100ps
module pac_video_select (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// control
	input  wire logic              enc_on,
	input  wire logic              authenticated,
	// result
	output pac_pkg::pac_vid_e      video_mode
);
	import pac_pkg::*;
	pac_vid_e next_video_mode;
	assign next_video_mode = !enc_on ? PAC_VID_PLAIN :
		(authenticated ? PAC_VID_ENCRYPT :
		PAC_VID_BLUE);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			video_mode <= PAC_VID_PLAIN;
		end else begin
			video_mode <= next_video_mode;
		end
	end
	a_video_encrypt: assert property (
		@(posedge clk) disable iff (!arst_n)
		(enc_on && authenticated)
		|=> (video_mode == PAC_VID_ENCRYPT))
		else $error("video not encrypted while enabled and authenticated");
	a_video_blue: assert property (
		@(posedge clk) disable iff (!arst_n)
		(enc_on && !authenticated)
		|=> (video_mode == PAC_VID_BLUE))
		else $error("blue screen missing while not authenticated");
	a_video_plain: assert property (
		@(posedge clk) disable iff (!arst_n)
		!enc_on
		|=> (video_mode == PAC_VID_PLAIN))
		else $error("video not plain with encryption off");
endmodule

// ---- bench/pac_control_tb_top.sv ----
// Purpose: self-checking bench for the protection control bits
// Assumes: strobes driven 1 ns after the rising edge
// Notes:   expected values come from the bit map, not from the design
`timescale 1ns/100ps
module pac_control_tb_top;
	import pac_pkg::*;
	logic              clk = 1'b0;
	logic              arst_n = 1'b0;
	logic              wr_en = 1'b0;
	logic              rd_en = 1'b0;
	logic [7:0]        wr_data = 8'h00;
	logic [7:0]        rd_data;
	logic [1:0]        enc_policy = 2'h0;
	logic              receiver_key_ready = 1'b0;
	logic              authenticated = 1'b0;
	logic              auth_enabled, auth_start_pulse, auth_restart_pulse, auth_stop_pulse;
	logic              receiver_key_approved, repeater_list_approved;
	logic              encryption_off, encryption_on;
	pac_vid_e          video_mode;
	int                errors = 0;
	int                compares = 0;
	pac_control dut (.clk(clk), .arst_n(arst_n), .wr_en(wr_en), .rd_en(rd_en),
		.wr_data(wr_data), .rd_data(rd_data), .enc_policy(enc_policy),
		.receiver_key_ready(receiver_key_ready), .authenticated(authenticated),
		.auth_enabled(auth_enabled), .auth_start_pulse(auth_start_pulse),
		.auth_restart_pulse(auth_restart_pulse), .auth_stop_pulse(auth_stop_pulse),
		.receiver_key_approved(receiver_key_approved),
		.repeater_list_approved(repeater_list_approved),
		.encryption_off(encryption_off), .encryption_on(encryption_on),
		.video_mode(video_mode));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// returns 1 ns after the write edge, when control outputs are fresh
	task automatic wr(input logic [7:0] d);
		@(posedge clk) #1 wr_en = 1'b1;
		wr_data = d;
		@(posedge clk) #1 wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] exp);
		@(posedge clk) #1 rd_en = 1'b1;
		@(posedge clk) #1 rd_en = 1'b0;
		chk(rd_data, exp);
	endtask
	task automatic step;
		@(posedge clk) #1;
	endtask
	function automatic logic [7:0] pulses;
		return {2'h0, auth_stop_pulse, auth_restart_pulse, auth_start_pulse,
			repeater_list_approved, encryption_off, auth_enabled};
	endfunction
	task automatic print_verdict;
		if (errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#5000;
		errors++;
		print_verdict();
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 arst_n = 1'b1;
		rd(PAC_CTRL_RESET);
		wr(8'h01);
		chk(pulses(), 8'h09);
		step();
		chk(pulses(), 8'h01);
		wr(8'h01);
		chk(pulses(), 8'h11);
		wr(8'h00);
		chk(pulses(), 8'h01);
		rd(8'h01);
		wr(8'h10);
		chk({7'h0, receiver_key_approved}, 8'h01);
		wr(8'h01);
		chk({7'h0, receiver_key_approved}, 8'h01);
		receiver_key_ready = 1'b1;
		step();
		step();
		chk({7'h0, receiver_key_approved}, 8'h00);
		receiver_key_ready = 1'b0;
		wr(8'h20);
		chk(pulses(), 8'h05);
		step();
		chk(pulses(), 8'h01);
		rd(8'h01);
		wr(8'h04);
		step();
		chk({6'h0, video_mode}, {6'h0, PAC_VID_BLUE});
		authenticated = 1'b1;
		step();
		step();
		chk({6'h0, video_mode}, {6'h0, PAC_VID_ENCRYPT});
		wr(8'h0C);
		chk(pulses(), 8'h03);
		step();
		chk({6'h0, video_mode}, {6'h0, PAC_VID_PLAIN});
		chk(pulses(), 8'h01);
		wr(8'h04);
		chk({6'h0, video_mode}, {6'h0, PAC_VID_ENCRYPT});
		rd(8'h05);
		// a write without bit 2 drops the stored enable
		wr(8'h30);
		enc_policy = PAC_POL_ALWAYS;
		step();
		chk({7'h0, encryption_on}, 8'h01);
		chk({6'h0, video_mode}, {6'h0, PAC_VID_ENCRYPT});
		wr(8'h02);
		chk(pulses(), 8'h20);
		rd(8'h14);
		enc_policy = PAC_POL_INBAND;
		step();
		rd(8'h10);
		chk({6'h0, video_mode}, {6'h0, PAC_VID_PLAIN});
		print_verdict();
	end
endmodule
